/* File: include/fmsq_pkg.sv */
package fmsq_pkg;

  // ----------------------------------------------------------------
  // widths and sizes
  // ----------------------------------------------------------------
  localparam int PC_W = 10;
  localparam int DATA_W = 8;
  localparam int SP_AW = 6;
  localparam int CTRL_W = 8;

  localparam logic [PC_W-1:0] PC_INIT = 10'h000;
  localparam logic [PC_W-1:0] PC_ONE = 10'h001;
  localparam logic [DATA_W-1:0] BYTE_ZERO = 8'h00;

  // ----------------------------------------------------------------
  // instruction field layout
  // ----------------------------------------------------------------
  localparam int ALU_OP_LSB = 0;
  localparam int JUMP_COND_LSB = 4;
  localparam int CLASS_LSB = 7;

  // bit 7 set marks a two-byte instruction (operand follows)
  // bit 3 selects jump vs move group in the two-byte class
  localparam int JUMP_FLAG_BIT = 3;

  // alu operations on bus and accumulator
  typedef enum logic [2:0] {
    FMSQ_ALU_LOAD = 3'h0,
    FMSQ_ALU_ADD = 3'h1,
    FMSQ_ALU_SUB = 3'h2,
    FMSQ_ALU_AND = 3'h3,
    FMSQ_ALU_OR = 3'h4,
    FMSQ_ALU_XOR = 3'h5,
    FMSQ_ALU_INC = 3'h6,
    FMSQ_ALU_HOLD = 3'h7
  } fmsq_alu_e;

  // jump conditions
  typedef enum logic [2:0] {
    FMSQ_JC_ALWAYS = 3'h0,
    FMSQ_JC_ZERO = 3'h1,
    FMSQ_JC_NZERO = 3'h2,
    FMSQ_JC_EXT0 = 3'h3,
    FMSQ_JC_EXT1 = 3'h4,
    FMSQ_JC_EXT2 = 3'h5,
    FMSQ_JC_EXT3 = 3'h6,
    FMSQ_JC_NEVER = 3'h7
  } fmsq_jcond_e;

  // one-byte source / destination selects (bits 6:4 when bit 7 clear)
  typedef enum logic [2:0] {
    FMSQ_SRC_STATUS = 3'h0,
    FMSQ_SRC_CMD = 3'h1,
    FMSQ_SRC_SCRATCH = 3'h2,
    FMSQ_DST_SCRATCH = 3'h3,
    FMSQ_DST_STATUS = 3'h4,
    FMSQ_DST_CTRL = 3'h5,
    FMSQ_DST_EXT = 3'h6,
    FMSQ_SRC_EXT = 3'h7
  } fmsq_sel_e;

  // decoded control lines
  typedef struct packed {
    logic alu_load;
    logic operand_drive;
    logic accumulator_drive_enable;
    logic status_port_enable;
    logic command_latch_output_enable;
    logic status_latch_load;
    logic control_strobe;
    logic scratch_read;
    logic scratch_write;
    logic ext_read;
    logic ext_write;
    logic jump_enable;
    logic two_byte;
  } fmsq_ctrl_s;

  // sequencer phases
  typedef enum logic [1:0] {
    FMSQ_FETCH = 2'b00,
    FMSQ_OPERAND = 2'b01,
    FMSQ_JUMP = 2'b10
  } fmsq_state_e;

endpackage : fmsq_pkg

/* File: hdl/fmsq_decoder.sv */
`timescale 1ns/100ps
module fmsq_decoder (
  // instruction in
  input wire logic [fmsq_pkg::DATA_W-1:0] instr,
  // decoded lines out
  output fmsq_pkg::fmsq_ctrl_s ctrl
);
  import fmsq_pkg::*;

  // ----------------------------------------------------------------
  // instruction decode
  // ----------------------------------------------------------------
  // each instruction raises one or more control lines
  always_comb begin
    logic [2:0] sel;
    sel = instr[JUMP_COND_LSB +: 3];
    ctrl = '0;
    ctrl.two_byte = instr[CLASS_LSB];
    if (instr[CLASS_LSB]) begin
      if (instr[JUMP_FLAG_BIT]) begin
        ctrl.jump_enable = 1'b1; // bus left free during jumps
      end else begin
        ctrl.operand_drive = 1'b1; // immediate onto the bus
        ctrl.alu_load = 1'b1;
      end
    end else begin
      unique case (fmsq_sel_e'(sel))
        FMSQ_SRC_STATUS: begin
          ctrl.status_port_enable = 1'b1;
          ctrl.alu_load = 1'b1;
        end
        FMSQ_SRC_CMD: begin
          ctrl.command_latch_output_enable = 1'b1;
          ctrl.alu_load = 1'b1;
        end
        FMSQ_SRC_SCRATCH: begin
          ctrl.scratch_read = 1'b1;
          ctrl.alu_load = 1'b1;
        end
        FMSQ_DST_SCRATCH: begin
          ctrl.accumulator_drive_enable = 1'b1;
          ctrl.scratch_write = 1'b1;
        end
        FMSQ_DST_STATUS: begin
          ctrl.accumulator_drive_enable = 1'b1;
          ctrl.status_latch_load = 1'b1;
        end
        FMSQ_DST_CTRL: begin
          ctrl.accumulator_drive_enable = 1'b1;
          ctrl.control_strobe = 1'b1;
        end
        FMSQ_DST_EXT: begin
          ctrl.accumulator_drive_enable = 1'b1;
          ctrl.ext_write = 1'b1;
        end
        FMSQ_SRC_EXT: begin
          ctrl.ext_read = 1'b1;
          ctrl.alu_load = 1'b1;
        end
      endcase
    end
  end

endmodule : fmsq_decoder

/* File: hdl/fmsq_alu.sv */
`timescale 1ns/100ps
module fmsq_alu (
  // operands
  input wire logic [fmsq_pkg::DATA_W-1:0] bus_in,
  input wire logic [fmsq_pkg::DATA_W-1:0] acc_in,
  input wire logic [2:0] alu_op_bits,
  // result
  output logic [fmsq_pkg::DATA_W-1:0] result
);
  import fmsq_pkg::*;

  // ----------------------------------------------------------------
  // arithmetic and logic
  // ----------------------------------------------------------------
  // combines the bus with the accumulator; sums wrap at eight bits
  always_comb begin
    unique case (fmsq_alu_e'(alu_op_bits))
      FMSQ_ALU_LOAD: result = bus_in;
      FMSQ_ALU_ADD: result = DATA_W'(acc_in + bus_in);
      FMSQ_ALU_SUB: result = DATA_W'(acc_in - bus_in);
      FMSQ_ALU_AND: result = acc_in & bus_in;
      FMSQ_ALU_OR: result = acc_in | bus_in;
      FMSQ_ALU_XOR: result = acc_in ^ bus_in;
      FMSQ_ALU_INC: result = DATA_W'(acc_in + 8'h01);
      FMSQ_ALU_HOLD: result = acc_in;
    endcase
  end

endmodule : fmsq_alu

/* File: hdl/fmsq_core.sv */
`timescale 1ns/100ps
module fmsq_core #(
  parameter int PROG_DEPTH = 1024,
  parameter int SCRATCH_DEPTH = 64,
  parameter logic [fmsq_pkg::DATA_W*1024-1:0] PROG_IMAGE = '0
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  input wire logic processor_init,
  // communications processor side
  input wire logic [fmsq_pkg::DATA_W-1:0] comm_processor_bus_in,
  input wire logic command_latch_write,
  input wire logic status_latch_read,
  output logic [fmsq_pkg::DATA_W-1:0] comm_processor_bus_out,
  output logic comm_processor_bus_oe,
  // shared formatter data bus
  input wire logic [fmsq_pkg::DATA_W-1:0] formatter_data_bus_in,
  output logic [fmsq_pkg::DATA_W-1:0] formatter_data_bus_out,
  output logic formatter_data_bus_oe,
  // system status and external jump conditions
  input wire logic [fmsq_pkg::DATA_W-1:0] system_status,
  input wire logic [3:0] ext_conditions,
  // system control and strobes
  output logic [fmsq_pkg::CTRL_W-1:0] system_control,
  output logic accumulator_drive_enable,
  output logic ext_write_strobe,
  output logic host_write_port_enable,
  output logic jump_load_strobe
);
  import fmsq_pkg::*;

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  initial begin
    if (PROG_DEPTH != (1 << PC_W) || SCRATCH_DEPTH != (1 << SP_AW)) begin
      $error("fmsq_core: memory depths must match address widths");
    end
    // the control latch is loaded straight from the data bus
    if (CTRL_W != DATA_W) begin
      $error("fmsq_core: control latch width must match the bus");
    end
  end

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic [1:0] rst_sync;
  logic rst_n;

  // two-stage release; assert stays asynchronous
  // every flop leaves reset on the same edge, never one ahead of the rest
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rst_sync <= 2'b00;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [PC_W-1:0] pc;
  logic [DATA_W-1:0] prog_mem [PROG_DEPTH];
  logic [DATA_W-1:0] prog_byte;
  logic [DATA_W-1:0] instr;
  logic [DATA_W-1:0] operand;
  logic [DATA_W-1:0] acc;
  logic [DATA_W-1:0] next_acc;
  logic [DATA_W-1:0] scratch [SCRATCH_DEPTH];
  logic [DATA_W-1:0] scratch_q;
  logic [DATA_W-1:0] status_latch;
  logic [DATA_W-1:0] command_latch;
  logic [DATA_W-1:0] bus_value;
  fmsq_state_e state;
  fmsq_ctrl_s ctrl;
  logic instruction_latch_enable;
  logic execute;
  logic acc_zero;
  logic acc_nzero;
  logic cond_true;
  logic take_jump;
  logic [DATA_W-1:0] operand_bus;
  logic [SP_AW-1:0] scratch_addr;

  // ----------------------------------------------------------------
  // program memory
  // ----------------------------------------------------------------
  // contents fixed at elaboration like a mask prom
  // a new program means a new image parameter; nothing can write it
  always_comb begin
    for (int i = 0; i < PROG_DEPTH; i++) begin
      prog_mem[i] = PROG_IMAGE[i*DATA_W +: DATA_W];
    end
  end
  assign prog_byte = prog_mem[pc];

  // ----------------------------------------------------------------
  // sequencing
  // ----------------------------------------------------------------
  // fetch latches the opcode; two-byte ops spend a cycle on the operand
  assign instruction_latch_enable = (state == FMSQ_FETCH);

  fmsq_decoder u_decoder (
    .instr (instr),
    .ctrl (ctrl)
  );

  // one-byte ops execute in the cycle after fetch, two-byte ops in their
  // operand cycle; either way every instruction spans two clocks
  assign execute = (state == FMSQ_OPERAND) ||
                   (state == FMSQ_JUMP && !ctrl.two_byte);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= FMSQ_FETCH;
    end else if (!processor_init) begin
      state <= FMSQ_FETCH;
    end else begin
      unique case (state)
        FMSQ_FETCH: state <= prog_byte[CLASS_LSB] ? FMSQ_OPERAND : FMSQ_JUMP;
        FMSQ_OPERAND: state <= FMSQ_FETCH;
        FMSQ_JUMP: state <= FMSQ_FETCH;
        default: state <= FMSQ_FETCH;
      endcase
    end
  end

  // instruction latch: loads on enable, held through operand fetch
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      instr <= BYTE_ZERO;
    end else if (instruction_latch_enable) begin
      instr <= prog_byte;
    end
  end

  // operand latch: opcode first (unused), then operand byte
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      operand <= BYTE_ZERO;
    end else if (state != FMSQ_JUMP) begin
      operand <= prog_byte;
    end
  end

  // ----------------------------------------------------------------
  // jump selector and zero detector
  // ----------------------------------------------------------------
  assign acc_zero = (acc == BYTE_ZERO);
  assign acc_nzero = !acc_zero;

  // condition picked by bits 6:4; pc at this point addresses the operand
  // external conditions are sampled as they stand; no synchroniser here
  always_comb begin
    unique case (fmsq_jcond_e'(instr[JUMP_COND_LSB +: 3]))
      FMSQ_JC_ALWAYS: cond_true = 1'b1;
      FMSQ_JC_ZERO: cond_true = acc_zero;
      FMSQ_JC_NZERO: cond_true = acc_nzero;
      FMSQ_JC_EXT0: cond_true = ext_conditions[0];
      FMSQ_JC_EXT1: cond_true = ext_conditions[1];
      FMSQ_JC_EXT2: cond_true = ext_conditions[2];
      FMSQ_JC_EXT3: cond_true = ext_conditions[3];
      FMSQ_JC_NEVER: cond_true = 1'b0;
    endcase
  end
  // strobe only with jump enable in the operand cycle
  assign take_jump = (state == FMSQ_OPERAND) && ctrl.jump_enable && cond_true;

  // ----------------------------------------------------------------
  // program counter
  // ----------------------------------------------------------------
  // target: low opcode bits above, operand byte below
  // the counter steps on every clock but a taken jump, so the byte after a one-byte op
  // is passed over; it is that op's scratch address
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pc <= PC_INIT;
    end else if (!processor_init) begin
      pc <= PC_INIT;
    end else if (take_jump) begin
      pc <= {instr[1:0], prog_byte};
    end else begin
      pc <= PC_W'(pc + PC_ONE);
    end
  end

  // ----------------------------------------------------------------
  // data bus sources
  // ----------------------------------------------------------------
  // a two-byte op executes while its operand byte is still on the
  // memory output; the latch takes it only at the end of that cycle,
  // so the bus path bypasses the latch for that single cycle
  assign operand_bus = (state == FMSQ_OPERAND) ? prog_byte : operand;

  // a one-byte op executes with the counter on the byte after it, which
  // the program reserves as the scratch address; the counter then steps
  // over it, so one-byte ops still take two bytes of program space
  assign scratch_addr = prog_byte[SP_AW-1:0];
  // read port is asynchronous so a scratch read completes in one cycle
  assign scratch_q = scratch[scratch_addr];

  // value seen on the shared bus by the alu
  always_comb begin
    bus_value = formatter_data_bus_in;
    if (ctrl.operand_drive) begin
      bus_value = operand_bus;
    end else if (ctrl.status_port_enable) begin
      bus_value = system_status;
    end else if (ctrl.command_latch_output_enable) begin
      bus_value = command_latch;
    end else if (ctrl.scratch_read) begin
      bus_value = scratch_q;
    end else if (ctrl.accumulator_drive_enable) begin
      bus_value = acc;
    end
  end

  fmsq_alu u_alu (
    .bus_in (bus_value),
    .acc_in (acc),
    .alu_op_bits (instr[ALU_OP_LSB +: 3]),
    .result (next_acc)
  );

  // accumulator keeps the alu result
  // only loading ops change it, so stores and jumps leave it intact
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      acc <= BYTE_ZERO;
    end else if (execute && ctrl.alu_load) begin
      acc <= next_acc;
    end
  end

  // scratch pad, written only from the accumulator drivers
  always_ff @(posedge clk) begin
    if (execute && ctrl.scratch_write && ctrl.accumulator_drive_enable) begin
      scratch[scratch_addr] <= acc;
    end
  end

  // ----------------------------------------------------------------
  // latches to the outside
  // ----------------------------------------------------------------
  // control latch loads from the bus on its strobe
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      system_control <= BYTE_ZERO;
    end else if (execute && ctrl.control_strobe) begin
      system_control <= bus_value;
    end
  end

  // status latch for the comm processor
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      status_latch <= BYTE_ZERO;
    end else if (execute && ctrl.status_latch_load) begin
      status_latch <= bus_value;
    end
  end

  // command latch, written by the comm processor
  // latest write wins; nothing tells the comm processor it was read
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      command_latch <= BYTE_ZERO;
    end else if (command_latch_write) begin
      command_latch <= comm_processor_bus_in;
    end
  end

  // status drive to the comm bus follows its read one cycle late
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      comm_processor_bus_out <= BYTE_ZERO;
      comm_processor_bus_oe <= 1'b0;
    end else begin
      comm_processor_bus_out <= status_latch;
      comm_processor_bus_oe <= status_latch_read;
    end
  end

  // ----------------------------------------------------------------
  // registered bus and strobe outputs
  // ----------------------------------------------------------------
  // outputs registered, so each reflects the execute cycle one clock later
  // the lag keeps every pin glitch free at the cost of one cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      formatter_data_bus_out <= BYTE_ZERO;
      formatter_data_bus_oe <= 1'b0;
      accumulator_drive_enable <= 1'b0;
      ext_write_strobe <= 1'b0;
    end else begin
      formatter_data_bus_out <= ctrl.accumulator_drive_enable ? acc :
        operand_bus;
      // released during jumps so buffer and host can use it
      formatter_data_bus_oe <= execute && !ctrl.jump_enable &&
        (ctrl.accumulator_drive_enable || ctrl.operand_drive);
      accumulator_drive_enable <= execute &&
        ctrl.accumulator_drive_enable;
      ext_write_strobe <= execute && ctrl.ext_write;
    end
  end

  // jump strobe and host write window both span the jump cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      jump_load_strobe <= 1'b0;
      host_write_port_enable <= 1'b0;
    end else begin
      jump_load_strobe <= take_jump;
      host_write_port_enable <= (state == FMSQ_OPERAND) &&
        ctrl.jump_enable;
    end
  end

endmodule : fmsq_core

/* File: dv/fmsq_core_sva.sv */
`timescale 1ns/100ps
module fmsq_core_sva (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  input wire logic processor_init,
  // communications processor side
  input wire logic status_latch_read,
  input wire logic comm_processor_bus_oe,
  // formatter side
  input wire logic formatter_data_bus_oe,
  input wire logic accumulator_drive_enable,
  input wire logic ext_write_strobe,
  input wire logic host_write_port_enable,
  input wire logic jump_load_strobe
);
  // ----------------------------------------------------------------
  // port relations
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  // a taken jump only ever lands inside the host write window
  jump_in_window_a: assert property (
    jump_load_strobe |-> host_write_port_enable)
    else $error("jump strobe outside host write window");
  bus_released_a: assert property (
    host_write_port_enable |-> !formatter_data_bus_oe)
    else $error("data bus driven during jump");
  jump_pulse_a: assert property (
    jump_load_strobe |=> !jump_load_strobe)
    else $error("jump strobe longer than one cycle");
  window_pulse_a: assert property (
    host_write_port_enable |=> !host_write_port_enable)
    else $error("host window longer than one cycle");
  // oe follows the read level one cycle late
  read_drive_a: assert property (
    $rose(status_latch_read) |=> comm_processor_bus_oe)
    else $error("status not driven after read");
  read_release_a: assert property (
    !status_latch_read |=> !comm_processor_bus_oe)
    else $error("comm bus driven without read");
  // pipeline must be flushed once init has been low a while
  init_hold_a: assert property (
    !processor_init [*3] |->
      !jump_load_strobe && !ext_write_strobe && !accumulator_drive_enable)
    else $error("activity while init held");
  acc_pulse_a: assert property (
    accumulator_drive_enable |=> !accumulator_drive_enable)
    else $error("accumulator drive longer than one cycle");
  ext_from_acc_a: assert property (
    ext_write_strobe |-> accumulator_drive_enable && formatter_data_bus_oe)
    else $error("external write without accumulator drive");
  no_store_jump_a: assert property (
    jump_load_strobe |-> !accumulator_drive_enable)
    else $error("accumulator store during jump");

  // main scenarios reached
  cover property (jump_load_strobe);
  cover property (ext_write_strobe);
  cover property ($rose(comm_processor_bus_oe));
endmodule : fmsq_core_sva

bind fmsq_core fmsq_core_sva u_sva (.*);

/* File: dv/fmsq_comm_model.sv */
`timescale 1ns/100ps
module fmsq_comm_model (
  // clock
  input wire logic clk,
  // communications processor bus
  input wire logic [7:0] bus_back,
  output logic [7:0] bus_drv,
  output logic command_latch_write,
  output logic status_latch_read
);
  // ----------------------------------------------------------------
  // bus cycles of the communications processor
  // ----------------------------------------------------------------
  initial begin
    bus_drv = 8'hA5;
    command_latch_write = 1'b0;
    status_latch_read = 1'b0;
  end

  // one-cycle write pulse, then the bus shows the inverse, not stale data
  task write_cmd(input logic [7:0] v);
    @(negedge clk);
    bus_drv = v;
    command_latch_write = 1'b1; // command pulse
    @(negedge clk);
    command_latch_write = 1'b0;
    bus_drv = ~v;
  endtask : write_cmd

  // read held until the registered status copy has settled
  task read_status(output logic [7:0] v);
    @(negedge clk);
    status_latch_read = 1'b1; // read request held
    repeat (3) @(negedge clk);
    v = bus_back;
    status_latch_read = 1'b0;
  endtask : read_status
endmodule : fmsq_comm_model

/* File: dv/formatter_microsequencer_tb.sv */
`timescale 1ns/100ps
module formatter_microsequencer_tb;
  import fmsq_pkg::*;
  // ----------------------------------------------------------------
  // program: every instruction takes two bytes, opcode then operand or scratch address
  // ----------------------------------------------------------------
  localparam logic [7:0] OPND [1:7] = '{8'h33, 8'h0D, 8'hC1, 8'h05, 8'hFF,
    8'h00, 8'h99};
  // status store, scratch store, zero jump over traps, untaken jumps, loop
  localparam logic [15:0] TAIL [0:16] = '{16'h4000, 16'h3005, 16'h8000,
    16'h982C, 16'h6000, 16'h6000, 16'hA800, 16'h2005, 16'h6000, 16'h1000,
    16'h6000, 16'h0000, 16'h6000, 16'h5000, 16'hF800, 16'h883E, 16'h6000};
  function automatic logic [8191:0] build_img();
    logic [8191:0] m;
    logic [15:0] w;
    m = '0;
    for (int i = 0; i < 33; i++) begin
      if (i < 2) w = (i == 1) ? 16'h6000 : 16'h805A;
      else if (i < 16) w = (i % 2) ? 16'h6000 : {5'h10, 3'(i / 2), OPND[i / 2]};
      else w = TAIL[i - 16];
      m[i*16 +: 16] = {w[7:0], w[15:8]};
    end
    return m;
  endfunction : build_img
  localparam logic [8191:0] IMG = build_img();

  function automatic logic [7:0] alu_ref(input logic [2:0] op,
    input logic [7:0] a, input logic [7:0] b);
    case (op)
      FMSQ_ALU_LOAD: return b;
      FMSQ_ALU_ADD: return a + b;
      FMSQ_ALU_SUB: return a - b;
      FMSQ_ALU_AND: return a & b;
      FMSQ_ALU_OR: return a | b;
      FMSQ_ALU_XOR: return a ^ b;
      FMSQ_ALU_INC: return a + 8'h01;
      default: return a;
    endcase
  endfunction : alu_ref

  // ----------------------------------------------------------------
  // signals, design and partner
  // ----------------------------------------------------------------
  logic clk, nrst, processor_init, cmd_wr, st_rd, cp_oe, fd_oe;
  logic acc_en, ext_wr, host_en, jls;
  logic [7:0] cm_drv, cp_out, fd_out, fd_drv, sys_status, sys_ctrl;
  logic [7:0] cmd, stat_exp, rd;
  logic [3:0] ext_cond;
  logic [7:0] exp_q [$];
  int error_cnt = 0;
  int total_checks = 0;
  int seed;
  // each shared wire carries the core's output while its enable is up, else the partner's drive
  wire logic [7:0] cp_wire = cp_oe ? cp_out : cm_drv;
  wire logic [7:0] fd_wire = fd_oe ? fd_out : fd_drv;

  fmsq_core #(.PROG_DEPTH(1024), .SCRATCH_DEPTH(64), .PROG_IMAGE(IMG)) DUT (
    .clk(clk), .nrst(nrst), .processor_init(processor_init),
    .comm_processor_bus_in(cp_wire), .command_latch_write(cmd_wr),
    .status_latch_read(st_rd), .comm_processor_bus_out(cp_out),
    .comm_processor_bus_oe(cp_oe), .formatter_data_bus_in(fd_wire),
    .formatter_data_bus_out(fd_out), .formatter_data_bus_oe(fd_oe),
    .system_status(sys_status), .ext_conditions(ext_cond),
    .system_control(sys_ctrl), .accumulator_drive_enable(acc_en),
    .ext_write_strobe(ext_wr), .host_write_port_enable(host_en),
    .jump_load_strobe(jls));

  fmsq_comm_model u_cm (.clk(clk), .bus_back(cp_wire), .bus_drv(cm_drv),
    .command_latch_write(cmd_wr), .status_latch_read(st_rd));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // checking
  // ----------------------------------------------------------------
  task check(input string name, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  task final_report();
    if (error_cnt == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : final_report

  // a trap or skipped jump shows up as an extra or misordered write
  always @(negedge clk) begin
    if (nrst && ext_wr === 1'b1) begin
      if (exp_q.size() == 0) check("ext_write_extra", 8'h00, 8'h01);
      else check("ext_write_data", exp_q.pop_front(), fd_out);
    end
  end

  // expected external writes of one pass through the program
  task push_all();
    logic [7:0] acc;
    acc = 8'h5A;
    exp_q.push_back(acc);
    for (int k = 1; k < 8; k++) begin
      acc = alu_ref(3'(k), acc, OPND[k]);
      exp_q.push_back(acc);
    end
    stat_exp = acc;
    exp_q.push_back(acc); // scratch round trip
    exp_q.push_back(cmd); // command read
    exp_q.push_back(sys_status); // status port read
  endtask : push_all

  // bounded wait; an extra write after the drain is caught by the monitor
  task wait_drain();
    for (int i = 0; i < 400 && exp_q.size() > 0; i++) @(negedge clk);
    check("drain_left", 8'h00, 8'(exp_q.size()));
    if (exp_q.size() > 0) final_report();
    repeat (10) @(negedge clk);
  endtask : wait_drain

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    seed = 32'h091b;
    nrst = 1'b0;
    processor_init = 1'b1;
    cmd = 8'($random(seed));
    sys_status = 8'($random(seed));
    fd_drv = 8'($random(seed));
    ext_cond = 4'($random(seed));
    repeat (3) @(negedge clk);
    nrst = 1'b1;
    repeat (2) @(negedge clk);
    u_cm.write_cmd(cmd);
    push_all();
    wait_drain();
    u_cm.read_status(rd);
    check("status_latch", stat_exp, rd);
    // the control write takes the bus while the accumulator holds status
    check("system_control", sys_status, sys_ctrl);
    // init mid-run restarts the program from the start
    processor_init = 1'b0;
    repeat (6) @(negedge clk);
    push_all();
    processor_init = 1'b1;
    wait_drain();
    final_report();
  end
endmodule : formatter_microsequencer_tb
